// ### logic/uc3_uart.v
// Serial port core: registers, ninth bits, transmitter and receiver
`include "uc3_map.vh"

module uc3_uart (
    input wire clk_sys,
    input wire sys_rst,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire rx_in,
    input wire tx_in,
    output wire tx_out,
    output wire tx_oe_n,
    output wire err_irq
);
    // ------------------------------------------------------------
    // Registers and shared baud tick
    // ------------------------------------------------------------
    reg [12:0] baud_div;
    reg [7:0] ctrl;
    reg [5:0] c3;
    reg tx_ninth_bit;
    wire tick;
    wire nine = ctrl[`UC3_CTRL_NINE];
    wire par_en = ctrl[`UC3_CTRL_PAR_EN];
    wire par_odd = ctrl[`UC3_CTRL_PAR_ODD];
    wire loopback_select = ctrl[`UC3_CTRL_LOOP];
    wire rx_source_select = ctrl[`UC3_CTRL_RX_SOURCE_SELECT];
    wire single = loopback_select & rx_source_select;
    wire wr_data = reg_wr & (reg_addr == `UC3_ADDR_DATA);
    wire rd_data = reg_rd & (reg_addr == `UC3_ADDR_DATA);
    wire rd_stat = reg_rd & (reg_addr == `UC3_ADDR_STAT);

    uc3_baud #(.DIV_W(13)) u_baud (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .divisor(baud_div),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    reg rx_s1, rx_s2, txi_s1, txi_s2;
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            txi_s1 <= 1'b1;
            txi_s2 <= 1'b1;
        end
        else
        begin
            rx_s1 <= rx_in;
            rx_s2 <= rx_s1;
            txi_s1 <= tx_in;
            txi_s2 <= txi_s1;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            baud_div <= `UC3_BAUD_RESET;
            ctrl <= `UC3_CTRL_RESET;
            c3 <= `UC3_C3_RESET;
            tx_ninth_bit <= 1'b0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `UC3_ADDR_BAUD_HI: baud_div[12:8] <= reg_wdata[4:0];
                `UC3_ADDR_BAUD_LO: baud_div[7:0] <= reg_wdata;
                `UC3_ADDR_CTRL: ctrl <= {1'b0, reg_wdata[6:0]};
                `UC3_ADDR_C3:
                begin
                    // Only a write here changes it, data writes do not
                    tx_ninth_bit <= reg_wdata[`UC3_C3_TX9];
                    c3 <= reg_wdata[5:0];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    reg [7:0] tx_buf;
    reg tx_full, tx_busy, tc;
    reg [10:0] tx_sh;
    reg [3:0] tx_cnt, tx_rt;
    wire tx_raw = tx_busy ? tx_sh[0] : 1'b1;
    wire tx_par9 = ^tx_buf ^ par_odd;
    wire tx_par8 = ^tx_buf[6:0] ^ par_odd;
    wire tx_bit8 = par_en ? tx_par9 : tx_ninth_bit;
    wire tx_bit7 = (par_en & ~nine) ? tx_par8 : tx_buf[7];

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            tx_buf <= 8'h00;
            tx_full <= 1'b0;
            tx_busy <= 1'b0;
            tc <= 1'b1;
            tx_sh <= 11'h7ff;
            tx_cnt <= 4'h0;
            tx_rt <= 4'h0;
        end
        else
        begin
            if (tick & tx_busy)
            begin
                tx_rt <= tx_rt + 4'h1;
                if (tx_rt == `UC3_RT_LAST)
                begin
                    tx_sh <= {1'b1, tx_sh[10:1]};
                    tx_cnt <= tx_cnt - 4'h1;
                    if (tx_cnt == 4'h1)
                    begin
                        tx_busy <= 1'b0;
                        tc <= ~tx_full;
                    end
                end
            end
            else if (tick & tx_full & ctrl[`UC3_CTRL_TX_EN])
            begin
                if (nine)
                    tx_sh <= {1'b1, tx_bit8, tx_buf, 1'b0};
                else
                    tx_sh <= {2'b11, tx_bit7, tx_buf[6:0], 1'b0};
                tx_cnt <= nine ? `UC3_FRAME9 : `UC3_FRAME8;
                tx_rt <= 4'h0;
                tx_busy <= 1'b1;
                tx_full <= 1'b0;
                tc <= 1'b0;
            end
            if (wr_data)
            begin
                tx_buf <= reg_wdata;
                tx_full <= 1'b1;
                tc <= 1'b0;
            end
        end
    end

    assign tx_out = tx_raw ^ c3[`UC3_C3_INV];
    assign tx_oe_n = single ? ~c3[`UC3_C3_DIR] : 1'b0;

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    reg rx_prev, rx_act, v_a, v_b, rx_noise, rx_armed;
    reg [3:0] rx_rt, rx_bit;
    reg [8:0] rx_sh;
    reg [7:0] rx_buf;
    reg rx_ninth_bit, rdrf, ovr, noise_flag;
    reg framing_error_flag, parity_error_flag;
    // In loopback the receiver hears the shifter, or the tx_in pin when single is set
    wire rx_line = single ? txi_s2 : (loopback_select ? tx_raw : rx_s2);
    wire maj = (v_a & v_b) | (v_a & rx_line) | (v_b & rx_line);
    wire unan = (v_a == v_b) & (v_b == rx_line);
    wire fall = rx_prev & ~rx_line;
    wire [3:0] rx_stop = nine ? `UC3_STOP9 : `UC3_STOP8;
    wire [7:0] rx_byte = nine ? rx_sh[7:0] : rx_sh[8:1];
    wire rx_par_bad = par_en &
        ((nine ? ^rx_sh : ^rx_sh[8:1]) ^ par_odd);
    wire rx_clear = rd_data & rx_armed;

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rx_prev <= 1'b1;
            rx_act <= 1'b0;
            v_a <= 1'b1;
            v_b <= 1'b1;
            rx_noise <= 1'b0;
            rx_armed <= 1'b0;
            rx_rt <= 4'h0;
            rx_bit <= 4'h0;
            rx_sh <= 9'h000;
            rx_buf <= 8'h00;
            rx_ninth_bit <= 1'b0;
            rdrf <= 1'b0;
            ovr <= 1'b0;
            noise_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
        end
        else
        begin
            // Status read arms; the data read finishes the clear
            if (rd_stat)
                rx_armed <= 1'b1;
            else if (rd_data)
                rx_armed <= 1'b0;
            if (rx_clear)
            begin
                rdrf <= 1'b0;
                ovr <= 1'b0;
                noise_flag <= 1'b0;
                framing_error_flag <= 1'b0;
                parity_error_flag <= 1'b0;
            end
            if (tick & ctrl[`UC3_CTRL_RX_EN])
            begin
                rx_prev <= rx_line;
                if (!rx_act)
                begin
                    if (fall)
                    begin
                        rx_act <= 1'b1;
                        rx_rt <= 4'h0;
                        rx_bit <= 4'h0;
                        rx_noise <= 1'b0;
                    end
                end
                else if (fall & (rx_bit != 4'h0))
                begin
                    rx_rt <= 4'h0;
                    rx_bit <= rx_bit + {3'h0, rx_rt[3] & (rx_bit != rx_stop)};
                end
                else
                begin
                    rx_rt <= rx_rt + 4'h1;
                    if (rx_bit == 4'h0)
                    begin
                        if (rx_rt == 4'h2)
                            v_a <= rx_line;
                        if (rx_rt == 4'h4)
                            v_b <= rx_line;
                        if ((rx_rt == `UC3_RT7) & maj)
                            rx_act <= 1'b0;
                        if (rx_rt == `UC3_RT_LAST)
                            rx_bit <= 4'h1;
                    end
                    else
                    begin
                        if (rx_rt == `UC3_RT8)
                            v_a <= rx_line;
                        if (rx_rt == `UC3_RT8 + 4'h1)
                            v_b <= rx_line;
                        if (rx_rt == `UC3_RT10)
                        begin
                            if (!unan)
                                rx_noise <= 1'b1;
                            if (rx_bit != rx_stop)
                                rx_sh <= {maj, rx_sh[8:1]};
                        end
                        if (rx_rt == `UC3_RT_LAST)
                            rx_bit <= rx_bit + 4'h1;
                        // Stop decided at RT10 so the next start is seen
                        if ((rx_rt == `UC3_RT10) & (rx_bit == rx_stop))
                        begin
                            rx_act <= 1'b0;
                            if (rdrf & ~rx_clear)
                                ovr <= 1'b1;
                            else
                            begin
                                rdrf <= 1'b1;
                                rx_buf <= rx_byte;
                                rx_ninth_bit <= nine & rx_sh[8];
                                noise_flag <= rx_noise | ~unan;
                                framing_error_flag <= ~maj;
                                parity_error_flag <= rx_par_bad;
                            end
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Error request
    // ------------------------------------------------------------
    wire or_req = ovr & c3[`UC3_C3_OR_EN];
    wire nf_req = noise_flag & c3[`UC3_C3_NF_EN];
    wire fe_req = framing_error_flag & c3[`UC3_C3_FE_EN];
    wire pf_req = parity_error_flag & c3[`UC3_C3_PF_EN];
    assign err_irq = or_req | nf_req | fe_req | pf_req;

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `UC3_ADDR_BAUD_HI: reg_rdata <= {3'h0, baud_div[12:8]};
                `UC3_ADDR_BAUD_LO: reg_rdata <= baud_div[7:0];
                `UC3_ADDR_CTRL: reg_rdata <= ctrl;
                `UC3_ADDR_STAT: reg_rdata <= {~tx_full, tc, rdrf,
                    rx_act, ovr, noise_flag, framing_error_flag,
                    parity_error_flag};
                `UC3_ADDR_C3: reg_rdata <= {rx_ninth_bit, tx_ninth_bit,
                    c3};
                `UC3_ADDR_DATA: reg_rdata <= rx_buf;
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end
endmodule // uc3_uart

// ### logic/uc3_map.vh
// Register offsets, field positions, reset values and timing counts
`ifndef UC3_MAP_VH
`define UC3_MAP_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UC3_ADDR_BAUD_HI 3'h0
`define UC3_ADDR_BAUD_LO 3'h1
`define UC3_ADDR_CTRL 3'h2
`define UC3_ADDR_STAT 3'h3
`define UC3_ADDR_C3 3'h4
`define UC3_ADDR_DATA 3'h5
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define UC3_CTRL_NINE 0
`define UC3_CTRL_PAR_EN 1
`define UC3_CTRL_PAR_ODD 2
`define UC3_CTRL_LOOP 3
`define UC3_CTRL_RX_SOURCE_SELECT 4
`define UC3_CTRL_TX_EN 5
`define UC3_CTRL_RX_EN 6
// ----------------------------------------------------------------
// Third control register fields
// ----------------------------------------------------------------
`define UC3_C3_RX9 7
`define UC3_C3_TX9 6
`define UC3_C3_DIR 5
`define UC3_C3_INV 4
`define UC3_C3_OR_EN 3
`define UC3_C3_NF_EN 2
`define UC3_C3_FE_EN 1
`define UC3_C3_PF_EN 0
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define UC3_CTRL_RESET 8'h00
`define UC3_C3_RESET 6'h00
`define UC3_BAUD_RESET 13'h0001
`define UC3_RT_LAST 4'hf
`define UC3_RT7 4'h6
`define UC3_RT8 4'h7
`define UC3_RT10 4'h9
`define UC3_FRAME8 4'ha
`define UC3_FRAME9 4'hb
`define UC3_STOP8 4'h9
`define UC3_STOP9 4'ha
`endif

// ### logic/uc3_baud.v
// Baud divider producing the 16x oversample enable pulse
module uc3_baud #(
    parameter DIV_W = 13
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [DIV_W-1:0] divisor,
    output reg tick
);
    reg [DIV_W-1:0] cnt;

    // Divisor zero stops the generator
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cnt <= {DIV_W{1'b0}};
            tick <= 1'b0;
        end
        else if (divisor == {DIV_W{1'b0}})
        begin
            cnt <= {DIV_W{1'b0}};
            tick <= 1'b0;
        end
        else if (cnt >= divisor - {{(DIV_W-1){1'b0}}, 1'b1})
        begin
            cnt <= {DIV_W{1'b0}};
            tick <= 1'b1;
        end
        else
        begin
            cnt <= cnt + {{(DIV_W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule // uc3_baud

// ### verification/uc3_remote.sv
// Remote serial device: frame sender and frame decoder on the line
module uc3_remote (
    input wire logic clk_sys,
    input wire logic line_in,
    input wire logic inv,
    input wire logic nine,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] rx_data = 9'h000;
    logic rx_stop = 1'b0;
    int n_got = 0;
    initial line_out = 1'b1;
    // ----
    // Sender: start, LSB first, stop, one idle bit
    // ----
    task automatic send(input logic [8:0] d, input int nb, input logic stp);
        for (int i = -1; i <= nb; i++)
        begin
            line_out <= (i < 0) ? 1'b0 : (i == nb) ? stp : d[i];
            repeat (16) @(posedge clk_sys);
        end
        line_out <= 1'b1;
        repeat (16) @(posedge clk_sys);
    endtask
    // ----
    // Decoder: mid-bit sampling, no resync, so a slow design shows up
    // ----
    always
    begin
        int nb;
        do
            @(posedge clk_sys);
        while ((line_in ^ inv) !== 1'b0);
        nb = nine ? 9 : 8;
        repeat (8) @(posedge clk_sys);
        for (int k = 0; k <= nb; k++)
        begin
            repeat (16) @(posedge clk_sys);
            if (k == nb)
                rx_stop = line_in ^ inv;
            else
                rx_data[k] = line_in ^ inv;
        end
        n_got++;
    end
endmodule // uc3_remote

// ### verification/uc3_uart_props.sv
// Port checker for the serial port core, bound to every instance
`include "uc3_map.vh"
module uc3_uart_props (
    input wire clk_sys,
    input wire sys_rst,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire rx_in,
    input wire tx_in,
    input wire tx_out,
    input wire tx_oe_n,
    input wire err_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] c3_sh;
    logic [6:0] ctrl_sh;
    logic [3:0] en_sh;
    assign en_sh = c3_sh[3:0];
    // ----
    // Shadows of what software last wrote
    // ----
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            c3_sh <= 7'h00;
            ctrl_sh <= 7'h00;
        end
        else if (reg_wr && reg_addr == `UC3_ADDR_C3)
            c3_sh <= reg_wdata[6:0];
        else if (reg_wr && reg_addr == `UC3_ADDR_CTRL)
            ctrl_sh <= reg_wdata[6:0];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    rdata_idle_a: assert property (!$past(reg_rd) |->
        reg_rdata == 8'h00)
        else $error("read data not zero outside an answer");
    unmapped_zero_a: assert property ($past(reg_rd) &&
        $past(reg_addr) > 3'h5 |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    c3_readback_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == `UC3_ADDR_C3 |-> reg_rdata[6:0] == $past(c3_sh))
        else $error("third control readback wrong");
    ctrl_readback_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == `UC3_ADDR_CTRL
        |-> reg_rdata == {1'b0, $past(ctrl_sh)})
        else $error("control readback wrong");
    irq_masked_a: assert property (en_sh == 4'h0 |-> !err_irq)
        else $error("interrupt while all enables off");
    irq_flags_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == `UC3_ADDR_STAT
        |-> $past(err_irq) == |(reg_rdata[3:0] & $past(en_sh)))
        else $error("interrupt not the OR of enabled flags");
    oe_dir_a: assert property (tx_oe_n ==
        (ctrl_sh[3] && ctrl_sh[4] && !c3_sh[5]))
        else $error("pin direction wrong");
    reset_out_a: assert property ($fell(sys_rst) |->
        reg_rdata == 8'h00 && !err_irq && tx_out && !tx_oe_n)
        else $error("outputs wrong after reset");
endmodule // uc3_uart_props
bind uc3_uart uc3_uart_props props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_in), .tx_in(tx_in),
    .tx_out(tx_out), .tx_oe_n(tx_oe_n), .err_irq(err_irq));

// ### verification/test_uc3_uart.sv
// Self-checking bench for the serial port core
`include "uc3_map.vh"
module test_uc3_uart;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rem_inv = 1'b0;
    logic rem_nine = 1'b1;
    logic [7:0] reg_rdata, rd_val;
    logic tx_out, tx_oe_n, err_irq, rem_line;
    logic [8:0] v, w;
    int n_errors = 0;
    int compares = 0;
    int seed = 55;
    wire tx_in = tx_oe_n ? rem_line : tx_out;
    always #20 clk_sys = ~clk_sys;
    uc3_uart DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_in(rem_line), .tx_in(tx_in),
        .tx_out(tx_out), .tx_oe_n(tx_oe_n), .err_irq(err_irq));
    uc3_remote rem (.clk_sys(clk_sys), .line_in(tx_out), .inv(rem_inv),
        .nine(rem_nine), .line_out(rem_line));
    // ----
    // Bus cycles, compares and bounded waits
    // ----
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic chk(input string nm, input logic [8:0] e,
        input logic [8:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic give_up;
        chk("wait bound", 9'h001, 9'h000);
        conclude();
    endtask
    task automatic wait_stat(input int b);
        for (int i = 0; i < 300; i++)
        begin
            rd(`UC3_ADDR_STAT);
            if (rd_val[b] === 1'b1)
                return;
        end
        give_up();
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 600 && rem.n_got < n; i++)
            @(posedge clk_sys);
        if (rem.n_got < n)
            give_up();
    endtask
    // Overrun or bad stop bit raises the enabled interrupt; the first byte is kept
    task automatic rx_err(input logic [7:0] en, input logic stp, input int b);
        wr(`UC3_ADDR_C3, en);
        v = $random(seed);
        w = $random(seed);
        rem.send(v, 9, stp);
        rem.send(w, 9, 1'b1);
        wait_stat(b);
        chk("irq set", 9'h001, {8'h00, err_irq});
        rd(`UC3_ADDR_DATA);
        chk("kept byte", {1'b0, v[7:0]}, {1'b0, rd_val});
        chk("irq clear", 9'h000, {8'h00, err_irq});
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(`UC3_ADDR_C3);
        chk("c3 reset", 9'h000, {1'b0, rd_val});
        rd(`UC3_ADDR_STAT);
        chk("stat reset", 9'h0c0, {1'b0, rd_val});
        rd(3'h7);
        chk("unmapped", 9'h000, {1'b0, rd_val});
        repeat (4)
        begin
            v = $random(seed) & 9'h06f;
            wr(`UC3_ADDR_C3, v[7:0]);
            rd(`UC3_ADDR_C3);
            chk("c3 rw", {2'b00, v[6:0]}, {2'b00, rd_val[6:0]});
        end
        wr(`UC3_ADDR_BAUD_HI, 8'h00);
        wr(`UC3_ADDR_BAUD_LO, 8'h01);
        wr(`UC3_ADDR_CTRL, 8'h61);
        for (int i = 0; i < 4; i++)
        begin
            if (i % 2 == 0)
            begin
                wr(`UC3_ADDR_C3, {1'b0, ~i[1], 1'b0, i[1], 4'h0});
                rem_inv = i[1];
                chk("idle level", {8'h00, ~i[1]}, {8'h00, tx_out});
            end
            v = $random(seed);
            wr(`UC3_ADDR_DATA, v[7:0]);
            wait_got(i + 1);
            chk("tx frame", {~i[1], v[7:0]}, rem.rx_data);
            chk("tx stop", 9'h001, {8'h00, rem.rx_stop});
        end
        wr(`UC3_ADDR_C3, 8'h00);
        rem_inv = 1'b0;
        v = $random(seed);
        fork
            rem.send(v, 9, 1'b1);
            wr(`UC3_ADDR_DATA, v[7:0] ^ 8'h5a);
        join
        wait_got(5);
        chk("duplex tx", {1'b0, v[7:0] ^ 8'h5a}, rem.rx_data);
        wait_stat(5);
        // Ninth bit is fetched before the data read clears the receive flags
        rd(`UC3_ADDR_C3);
        chk("rx ninth", {8'h00, v[8]}, {8'h00, rd_val[7]});
        rd(`UC3_ADDR_DATA);
        chk("rx byte", {1'b0, v[7:0]}, {1'b0, rd_val});
        rd(`UC3_ADDR_STAT);
        chk("rdrf clear", 9'h000, {8'h00, rd_val[5]});
        rx_err(8'h08, 1'b1, 3);
        rx_err(8'h02, 1'b0, 1);
        wr(`UC3_ADDR_CTRL, 8'h62);
        wr(`UC3_ADDR_C3, 8'h01);
        rem_nine = 1'b0;
        for (int j = 0; j < 2; j++)
        begin
            v = $random(seed);
            v[7] = ^v[6:0] ^ (j == 0);
            rem.send(v, 8, 1'b1);
            wait_stat(5);
            chk("parity flag", {8'h00, j == 0}, {8'h00, rd_val[0]});
            chk("parity irq", {8'h00, j == 0}, {8'h00, err_irq});
            rd(`UC3_ADDR_DATA);
        end
        wr(`UC3_ADDR_CTRL, 8'h18);
        for (int d = 0; d < 2; d++)
        begin
            wr(`UC3_ADDR_C3, {2'b00, d[0], 5'h00});
            chk("pin drive", {8'h00, ~d[0]}, {8'h00, tx_oe_n});
        end
        conclude();
    end
endmodule // test_uc3_uart
